// ==== hw/acw_pkg.sv ====
// Purpose: Constants shared by the converter control block
// Assumes: Registers sit on the 8-bit special-function register port
// Notes: Offsets are byte addresses on that port
package acw_pkg;
    // ==========================================================
    // Register addresses
    localparam logic [7:0] ADDR_CHANNEL = 8'hbb;
    localparam logic [7:0] ADDR_CONFIG = 8'hbc;
    localparam logic [7:0] ADDR_RESULT = 8'hbe;
    localparam logic [7:0] ADDR_LOWER = 8'hc4;
    localparam logic [7:0] ADDR_UPPER = 8'hc5;
    localparam logic [7:0] ADDR_CONTROL = 8'he8;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CHANNEL = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'hf8;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [7:0] RST_LOWER = 8'hff;
    localparam logic [7:0] RST_UPPER = 8'h00;
    // ==========================================================
    // Control register fields
    localparam int CTL_ENABLE = 7;
    localparam int CTL_TRACK_MODE = 6;
    localparam int CTL_DONE = 5;
    localparam int CTL_BUSY = 4;
    localparam int CTL_WINDOW = 3;
    // Configuration register fields
    localparam int CFG_DIV_LSB = 3;
    localparam int CFG_UNUSED = 2;
    // Start mode codes
    localparam logic [2:0] START_SOFTWARE = 3'h0;
    localparam logic [2:0] START_TIMER0 = 3'h1;
    localparam logic [2:0] START_TIMER2 = 3'h2;
    localparam logic [2:0] START_TIMER1 = 3'h3;
    // ==========================================================
    // Timing in conversion clocks
    localparam logic [3:0] TRACK_CLOCKS = 4'h3;
    localparam logic [3:0] CONVERT_CLOCKS = 4'h8;
endpackage : acw_pkg

// ==== hw/acw_adc_control.sv ====
// Purpose: Control side of an 8-bit converter with window detector
// Assumes: Register port and all inputs synchronous to clk
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ps

// Summary of operation
// - Negative codes 0-7 pick port pins; top bit set picks ground.
// - Ground negative input means single-ended, otherwise differential.
// - Positive codes 0-7 port pins, 8 temperature, 9 supply, rest reserved.
// - Conversion clock is system clock over divider field plus one, bits 7-3.
// - Gain code 00,01,10,11 gives gain 0.5,1,2,4.
// - Configuration bit 2 reads zero, writes ignored.
// - Result holds last conversion byte, unsigned or signed by mode.
// - Enable clear is shutdown; set is active and ready.
// - Normal track mode tracks always except during conversion.
// - Done flag sets at conversion end and holds until cleared.
// - Writing busy one starts conversion only with start mode 000.
// - Window flag sets on match and holds until cleared.
// - Start mode picks software, timer 0, timer 2, timer 1 or pin edge.
// - Low-power modes 000-011 track three conversion clocks, then convert.
// - Low-power pin mode tracks while pin low, converts on rising edge.
// - Every result is compared against both limits to set window flag.
// - Inside or outside detection follows only from the limit values.
// - Lower below upper flags results strictly between them.
// - Compare unsigned in single-ended, signed in differential mode.
// - Busy high during conversion; its fall sets the done flag.
// - Timer 2 trigger uses low overflow in 8-bit, high in 16-bit.
// - Conversion takes at least eight conversion clocks after tracking.
module acw_adc_control #(
    parameter int DATA_W = 8
) (
    // System
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Start sources
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic timer2_low_ovf,
    input wire logic timer2_high_ovf,
    input wire logic timer2_split,
    input wire logic external_start_pin,
    // Analog core
    input wire logic [DATA_W-1:0] sar_data,
    output logic [3:0] negative_input_code,
    output logic [3:0] positive_input_code,
    output logic negative_ground,
    output logic single_ended,
    output logic [1:0] amplifier_gain_code,
    output logic converter_enable,
    output logic conversion_clock,
    output logic track_hold,
    output logic converting,
    output logic conversion_done_flag,
    output logic window_match_flag
);

    // ==========================================================
    // Registers
    typedef enum logic [1:0] {ACW_IDLE, ACW_TRACK, ACW_CONVERT} acw_state_t;
    acw_state_t state_r;
    logic [7:0] channel_r;
    logic [7:0] config_r;
    logic [7:0] result_r;
    logic [7:0] lower_r;
    logic [7:0] upper_r;
    logic enable_r, track_mode_r, done_r, window_r;
    logic [2:0] start_mode_r;
    logic [4:0] div_cnt_r;
    logic tick;
    logic [3:0] step_r;
    logic pin_prev_r;
    logic trigger, pin_rise, finish, match;

    // Window compare in the mode of the current channel selection
    function automatic logic window_hit(input logic [7:0] res, input logic [7:0] lo,
                                        input logic [7:0] hi, input logic sgn);
        logic [7:0] r, l, h;
        r = {res[7] ^ sgn, res[6:0]};
        l = {lo[7] ^ sgn, lo[6:0]};
        h = {hi[7] ^ sgn, hi[6:0]};
        if (l < h) begin
            window_hit = (r > l) && (r < h);
        end else begin
            window_hit = (r < h) || (r > l);
        end
    endfunction : window_hit

    wire logic wr_ctl = sfr_wr && (sfr_addr == acw_pkg::ADDR_CONTROL);
    wire logic diff_mode = !channel_r[7];

    // ==========================================================
    // Register writes
    always_ff @(posedge clk) begin
        if (reset) begin
            channel_r <= acw_pkg::RST_CHANNEL;
            config_r <= acw_pkg::RST_CONFIG;
            lower_r <= acw_pkg::RST_LOWER;
            upper_r <= acw_pkg::RST_UPPER;
        end else if (sfr_wr) begin
            if (sfr_addr == acw_pkg::ADDR_CHANNEL) begin
                channel_r <= sfr_wdata;
            end
            if (sfr_addr == acw_pkg::ADDR_CONFIG) begin
                config_r <= sfr_wdata & 8'hfb;
            end
            if (sfr_addr == acw_pkg::ADDR_LOWER) begin
                lower_r <= sfr_wdata;
            end
            if (sfr_addr == acw_pkg::ADDR_UPPER) begin
                upper_r <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            enable_r <= 1'b0;
            track_mode_r <= 1'b0;
            start_mode_r <= 3'h0;
        end else if (wr_ctl) begin
            enable_r <= sfr_wdata[acw_pkg::CTL_ENABLE];
            track_mode_r <= sfr_wdata[acw_pkg::CTL_TRACK_MODE];
            start_mode_r <= sfr_wdata[2:0];
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            done_r <= 1'b0;
            window_r <= 1'b0;
            result_r <= acw_pkg::RST_RESULT;
        end else begin
            if (finish) begin
                result_r <= sar_data;
            end else if (sfr_wr && sfr_addr == acw_pkg::ADDR_RESULT) begin
                result_r <= sfr_wdata;
            end
            if (finish) begin
                done_r <= 1'b1;
            end else if (wr_ctl) begin
                done_r <= sfr_wdata[acw_pkg::CTL_DONE];
            end
            if (finish && match) begin
                window_r <= 1'b1;
            end else if (wr_ctl) begin
                window_r <= sfr_wdata[acw_pkg::CTL_WINDOW];
            end
        end
    end

    assign match = window_hit(sar_data, lower_r, upper_r, diff_mode);

    // ==========================================================
    // Read port
    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                acw_pkg::ADDR_CHANNEL: sfr_rdata <= channel_r;
                acw_pkg::ADDR_CONFIG: sfr_rdata <= config_r & 8'hfb;
                acw_pkg::ADDR_RESULT: sfr_rdata <= result_r;
                acw_pkg::ADDR_LOWER: sfr_rdata <= lower_r;
                acw_pkg::ADDR_UPPER: sfr_rdata <= upper_r;
                acw_pkg::ADDR_CONTROL: sfr_rdata <= {enable_r, track_mode_r, done_r,
                                                     state_r != ACW_IDLE, window_r, start_mode_r};
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Conversion clock divider; runs only while enabled to save power
    always_ff @(posedge clk) begin
        if (reset || !enable_r) begin
            div_cnt_r <= 5'h00;
        end else if (state_r == ACW_IDLE && trigger) begin
            // Restart on a start so no partial conversion clock is counted
            div_cnt_r <= 5'h00;
        end else if (div_cnt_r >= config_r[7:acw_pkg::CFG_DIV_LSB]) begin
            div_cnt_r <= 5'h00;
        end else begin
            div_cnt_r <= div_cnt_r + 5'h01;
        end
    end

    assign tick = enable_r && (div_cnt_r >= config_r[7:acw_pkg::CFG_DIV_LSB]);

    always_ff @(posedge clk) begin
        if (reset) begin
            conversion_clock <= 1'b0;
        end else begin
            conversion_clock <= enable_r && (div_cnt_r <= {1'b0, config_r[7:4]});
        end
    end

    // ==========================================================
    // Start selection
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_prev_r <= 1'b1;
        end else begin
            pin_prev_r <= external_start_pin;
        end
    end

    assign pin_rise = external_start_pin && !pin_prev_r;

    always_comb begin
        trigger = 1'b0;
        if (start_mode_r[2]) begin
            trigger = pin_rise;
        end else begin
            unique case (start_mode_r[1:0])
                acw_pkg::START_SOFTWARE[1:0]: trigger = wr_ctl && sfr_wdata[acw_pkg::CTL_BUSY];
                acw_pkg::START_TIMER0[1:0]: trigger = timer0_ovf;
                acw_pkg::START_TIMER2[1:0]: trigger = timer2_split ? timer2_low_ovf : timer2_high_ovf;
                acw_pkg::START_TIMER1[1:0]: trigger = timer1_ovf;
            endcase
        end
    end

    // ==========================================================
    // Track and convert sequence
    assign finish = (state_r == ACW_CONVERT) && tick && (step_r == acw_pkg::CONVERT_CLOCKS - 4'h1);

    always_ff @(posedge clk) begin
        if (reset || !enable_r) begin
            state_r <= ACW_IDLE;
            step_r <= 4'h0;
        end else begin
            unique case (state_r)
                ACW_IDLE: begin
                    step_r <= 4'h0;
                    if (trigger) begin
                        state_r <= (track_mode_r && !start_mode_r[2]) ? ACW_TRACK : ACW_CONVERT;
                    end
                end
                ACW_TRACK: begin
                    if (tick) begin
                        if (step_r == acw_pkg::TRACK_CLOCKS - 4'h1) begin
                            state_r <= ACW_CONVERT;
                            step_r <= 4'h0;
                        end else begin
                            step_r <= step_r + 4'h1;
                        end
                    end
                end
                ACW_CONVERT: begin
                    if (finish) begin
                        state_r <= ACW_IDLE;
                    end else if (tick) begin
                        step_r <= step_r + 4'h1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Outputs to the analog core
    always_ff @(posedge clk) begin
        if (reset) begin
            negative_input_code <= 4'h0;
            positive_input_code <= 4'h0;
            negative_ground <= 1'b0;
            single_ended <= 1'b0;
            amplifier_gain_code <= 2'h0;
            converter_enable <= 1'b0;
            track_hold <= 1'b0;
            converting <= 1'b0;
            conversion_done_flag <= 1'b0;
            window_match_flag <= 1'b0;
        end else begin
            negative_input_code <= channel_r[7:4];
            positive_input_code <= channel_r[3:0];
            negative_ground <= channel_r[7];
            single_ended <= channel_r[7];
            amplifier_gain_code <= config_r[1:0];
            converter_enable <= enable_r;
            if (!enable_r) begin
                track_hold <= 1'b0;
            end else if (!track_mode_r) begin
                track_hold <= (state_r != ACW_CONVERT);
            end else if (start_mode_r[2]) begin
                track_hold <= (state_r == ACW_IDLE) && !external_start_pin;
            end else begin
                track_hold <= (state_r == ACW_TRACK);
            end
            converting <= enable_r && (state_r == ACW_CONVERT) && !finish;
            conversion_done_flag <= done_r;
            window_match_flag <= window_r;
        end
    end

    // ==========================================================
    // Checks
    // Cycles spent converting; a divider change during a conversion voids the length check
    logic [8:0] conv_cyc_r;
    logic cfg_moved_r;

    always_ff @(posedge clk) begin
        if (reset || state_r != ACW_CONVERT) begin
            conv_cyc_r <= 9'h000;
        end else begin
            conv_cyc_r <= conv_cyc_r + 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || state_r == ACW_IDLE) begin
            cfg_moved_r <= 1'b0;
        end else if (sfr_wr && sfr_addr == acw_pkg::ADDR_CONFIG) begin
            cfg_moved_r <= 1'b1;
        end
    end

    a_gnd_single: assert property (@(posedge clk) disable iff (reset)
        ##1 single_ended == $past(channel_r[7]) && negative_ground == single_ended)
        else $error("single-ended mode does not follow ground selection");
    a_cfg_bit2: assert property (@(posedge clk) disable iff (reset)
        sfr_rd && sfr_addr == acw_pkg::ADDR_CONFIG |=> !sfr_rdata[acw_pkg::CFG_UNUSED])
        else $error("configuration bit 2 read as one");
    a_div_tick: assert property (@(posedge clk) disable iff (reset)
        tick && $stable(config_r) |-> div_cnt_r == config_r[7:3] ##1 div_cnt_r == 5'h00)
        else $error("divider tick at wrong count");
    a_done_set: assert property (@(posedge clk) disable iff (reset)
        finish |=> done_r && result_r == $past(sar_data) && state_r == ACW_IDLE)
        else $error("completion did not load result and flag");
    a_sw_start: assert property (@(posedge clk) disable iff (reset)
        state_r == ACW_IDLE && enable_r && wr_ctl && sfr_wdata[7] && sfr_wdata[4]
        && !track_mode_r && start_mode_r == 3'h0 |=> state_r == ACW_CONVERT)
        else $error("busy write did not start conversion");
    a_track_len: assert property (@(posedge clk) disable iff (reset)
        state_r == ACW_TRACK && tick && step_r == 4'h2 && enable_r && !(wr_ctl && !sfr_wdata[7])
        |=> state_r == ACW_CONVERT && step_r == 4'h0)
        else $error("tracking period not three clocks");
    a_conv_len: assert property (@(posedge clk) disable iff (reset)
        finish && !cfg_moved_r |-> 10'(conv_cyc_r) + 10'h001 >= {2'h0, config_r[7:3], 3'h0} + 10'h008)
        else $error("conversion shorter than eight clocks");
    a_window_set: assert property (@(posedge clk) disable iff (reset)
        finish && match |=> window_r ##1 window_match_flag)
        else $error("window match did not raise flag");
    a_shutdown: assert property (@(posedge clk) disable iff (reset)
        !enable_r |=> state_r == ACW_IDLE && !converting)
        else $error("converter active while disabled");

endmodule : acw_adc_control

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the converter control block
// Assumes: Inputs change on falling clk edges; register reads are checked from a note queue
// Notes: Conversion clock divider kept small so every conversion finishes quickly
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // Signals
    logic clk, reset, sfr_wr, sfr_rd, rd_d;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, sar_data;
    logic timer0_ovf, timer1_ovf, timer2_low_ovf, timer2_high_ovf, timer2_split, external_start_pin;
    logic [3:0] negative_input_code, positive_input_code;
    logic [1:0] amplifier_gain_code;
    logic negative_ground, single_ended, converter_enable, conversion_clock, track_hold, converting;
    logic conversion_done_flag, window_match_flag;
    typedef struct {string name; logic [7:0] exp;} acw_note_t;
    acw_note_t notes[$];
    int n_mismatch = 0, total_checks = 0, seed = 32'hcbcc, lat0, lat, nb, p, m;
    int mtab[6] = '{1, 2, 2, 3, 4, 7};
    logic [3:0] sel;

    acw_adc_control dut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf),
        .timer2_low_ovf(timer2_low_ovf), .timer2_high_ovf(timer2_high_ovf), .timer2_split(timer2_split),
        .external_start_pin(external_start_pin), .sar_data(sar_data),
        .negative_input_code(negative_input_code), .positive_input_code(positive_input_code),
        .negative_ground(negative_ground), .single_ended(single_ended),
        .amplifier_gain_code(amplifier_gain_code), .converter_enable(converter_enable),
        .conversion_clock(conversion_clock), .track_hold(track_hold), .converting(converting),
        .conversion_done_flag(conversion_done_flag), .window_match_flag(window_match_flag));

    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        @(negedge clk);
    endtask : wr

    // Expectation is queued before the strobe so the monitor always finds it
    task automatic rd(input logic [7:0] a, input string name, input logic [7:0] exp);
        notes.push_back('{name, exp});
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        @(negedge clk);
    endtask : rd

    task automatic pulse(input logic [3:0] s);
        {timer2_high_ovf, timer2_low_ovf, timer1_ovf, timer0_ovf} = s;
        @(negedge clk);
        {timer2_high_ovf, timer2_low_ovf, timer1_ovf, timer0_ovf} = 4'h0;
        @(negedge clk);
    endtask : pulse

    task automatic wait_done(output int l, output int n);
        l = 0;
        n = 0;
        while (conversion_done_flag !== 1'b1 && l < 400) begin
            if (converting === 1'b1) begin
                n++;
                chk("track_in_convert", 8'h00, track_hold);
            end
            @(negedge clk);
            l++;
        end
        chk("done_seen", 8'h01, conversion_done_flag);
    endtask : wait_done

    // Period measured between two rising edges, counted in system clocks
    task automatic clk_period(output int n);
        int k;
        k = 0;
        n = 0;
        for (int ph = 0; ph < 4; ph++) begin
            while (conversion_clock !== ph[0] && k < 200) begin
                @(negedge clk);
                k++;
                if (ph >= 2) n++;
            end
        end
    endtask : clk_period

    task automatic win_case(input logic [7:0] chan, lo, up, data, input logic exp);
        wr(acw_pkg::ADDR_CHANNEL, chan);
        wr(acw_pkg::ADDR_LOWER, lo);
        wr(acw_pkg::ADDR_UPPER, up);
        sar_data = data;
        wr(acw_pkg::ADDR_CONTROL, 8'h80);
        wr(acw_pkg::ADDR_CONTROL, 8'h90);
        wait_done(lat, nb);
        chk("window_flag", {7'h00, exp}, window_match_flag);
        rd(acw_pkg::ADDR_RESULT, "result", data);
        rd(acw_pkg::ADDR_CONTROL, "control", {4'ha, exp, 3'h0});
    endtask : win_case

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // Clock, read monitor, watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) rd_d <= sfr_rd && !reset;

    always @(negedge clk) begin
        if (rd_d === 1'b1 && notes.size() > 0) begin
            chk(notes[0].name, notes[0].exp, sfr_rdata);
            void'(notes.pop_front());
        end
    end

    // Whole sequence needs under a thousand cycles; thirty thousand cycles is a hang
    initial begin
        #3_000_000;
        n_mismatch++;
        $display("MISMATCH watchdog expected finish seen hang");
        end_sim();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {reset, rd_d} = 2'b10;
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, sar_data} = '0;
        {timer0_ovf, timer1_ovf, timer2_low_ovf, timer2_high_ovf, timer2_split, external_start_pin} = '0;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chk("ground_at_reset", 8'h00, single_ended);
        chk("enable_at_reset", 8'h00, converter_enable);
        rd(acw_pkg::ADDR_CONFIG, "config_reset", acw_pkg::RST_CONFIG);
        rd(acw_pkg::ADDR_CHANNEL, "channel_reset", acw_pkg::RST_CHANNEL);
        rd(acw_pkg::ADDR_RESULT, "result_reset", acw_pkg::RST_RESULT);
        rd(acw_pkg::ADDR_CONTROL, "control_reset", 8'h00);
        rd(8'h10, "unmapped", 8'h00);
        for (int i = 0; i < 16; i++) begin
            p = $random(seed);
            wr(acw_pkg::ADDR_CHANNEL, {i[3:0], p[3:0]});
            chk("negative_code", {4'h0, i[3:0]}, negative_input_code);
            chk("negative_ground", {7'h00, i[3]}, negative_ground);
            chk("single_ended", {7'h00, i[3]}, single_ended);
            chk("positive_code", {4'h0, p[3:0]}, positive_input_code);
            rd(acw_pkg::ADDR_CHANNEL, "channel", {i[3:0], p[3:0]});
        end
        for (int g = 0; g < 4; g++) begin
            wr(acw_pkg::ADDR_CONFIG, {5'h03, 1'b1, g[1:0]});
            chk("gain", {6'h00, g[1:0]}, amplifier_gain_code);
            rd(acw_pkg::ADDR_CONFIG, "config_unused", {5'h03, 1'b0, g[1:0]});
        end
        wr(acw_pkg::ADDR_CONTROL, 8'h80);
        clk_period(p);
        chk("divider_3", 8'h04, p[7:0]);
        wr(acw_pkg::ADDR_CONFIG, {5'h06, 3'h0});
        clk_period(p);
        chk("divider_6", 8'h07, p[7:0]);
        // Software start, normal tracking, divider 1
        wr(acw_pkg::ADDR_CONFIG, {5'h01, 3'h0});
        chk("track_idle", 8'h01, track_hold);
        sar_data = 8'($random(seed));
        wr(acw_pkg::ADDR_CONTROL, 8'h90);
        wait_done(lat0, nb);
        // Eight conversion clocks of two system clocks, less the launch cycle
        chk("convert_length", 8'h01, {7'h00, nb >= 15 && nb <= 17});
        rd(acw_pkg::ADDR_RESULT, "result", sar_data);
        rd(acw_pkg::ADDR_CONTROL, "control_done", 8'ha0);
        repeat (20) @(negedge clk);
        chk("done_held", 8'h01, conversion_done_flag);
        wr(acw_pkg::ADDR_CONTROL, 8'h80);
        chk("done_cleared", 8'h00, conversion_done_flag);
        repeat (5) @(negedge clk);
        chk("busy_zero_write", 8'h00, converting);
        // Low-power software start adds three conversion clocks of tracking
        wr(acw_pkg::ADDR_CONTROL, 8'hc0);
        wr(acw_pkg::ADDR_CONTROL, 8'hd0);
        wait_done(lat, nb);
        chk("lowpower_extra", 8'h06, 8'(lat - lat0));
        // Disable in mid conversion
        wr(acw_pkg::ADDR_CONTROL, 8'h80);
        wr(acw_pkg::ADDR_CONTROL, 8'h90);
        wr(acw_pkg::ADDR_CONTROL, 8'h00);
        chk("disabled", 8'h00, converter_enable);
        repeat (30) @(negedge clk);
        chk("abort_no_done", 8'h00, conversion_done_flag);
        chk("abort_idle", 8'h00, converting);
        // Each timer and pin start source, with the busy bit and every other timer overflow fired first
        for (int j = 0; j < 6; j++) begin
            m = mtab[j];
            timer2_split = (j == 1);
            sel = (m == 1) ? 4'h1 : (m == 3) ? 4'h2 : (m == 2) ? (timer2_split ? 4'h4 : 4'h8) : 4'h0;
            wr(acw_pkg::ADDR_CONTROL, {5'h10, m[2:0]});
            wr(acw_pkg::ADDR_CONTROL, {5'h12, m[2:0]});
            pulse(~sel);
            chk("wrong_source", 8'h00, converting);
            if (m >= 4) external_start_pin = 1'b1;
            else pulse(sel);
            wait_done(lat, nb);
            wr(acw_pkg::ADDR_CONTROL, {5'h10, m[2:0]});
            external_start_pin = 1'b0;
        end
        // Low-power pin mode tracks only while the pin is low
        wr(acw_pkg::ADDR_CONTROL, 8'hc4);
        chk("pin_low_track", 8'h01, track_hold);
        external_start_pin = 1'b1;
        wait_done(lat, nb);
        chk("pin_high_hold", 8'h00, track_hold);
        external_start_pin = 1'b0;
        win_case(8'h80, 8'h10, 8'h20, 8'h15, 1'b1);
        win_case(8'h80, 8'h10, 8'h20, 8'h10, 1'b0);
        win_case(8'h80, 8'h10, 8'h20, 8'h20, 1'b0);
        win_case(8'h80, 8'h20, 8'h10, 8'h05, 1'b1);
        win_case(8'h80, 8'h20, 8'h10, 8'h15, 1'b0);
        win_case(8'h80, 8'h20, 8'h10, 8'h25, 1'b1);
        win_case(8'h00, 8'hff, 8'h10, 8'h00, 1'b1);
        win_case(8'h00, 8'hff, 8'h10, 8'hff, 1'b0);
        win_case(8'h00, 8'hff, 8'h10, 8'h80, 1'b0);
        win_case(8'h00, 8'h10, 8'hff, 8'h80, 1'b1);
        win_case(8'h00, 8'h10, 8'hff, 8'h05, 1'b0);
        win_case(8'h00, 8'h10, 8'hff, 8'h20, 1'b1);
        end_sim();
    end
endmodule : tb_top
